// ### core/pces_flag.sv
// One sticky write-one-to-clear flag
// Assumes a single clock and synchronous active-high reset.
`timescale 1ns/1ps
module pces_flag (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Set and clear
  input wire logic i_set,
  input wire logic i_clear,
  // Flag state
  output logic o_flag
);

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_flag <= 1'b0;
    end else if (i_set) begin
      o_flag <= 1'b1;
    end else if (i_clear) begin
      o_flag <= 1'b0;
    end
  end

endmodule : pces_flag

// ### core/pces_pkg.sv
// Package for the primary cache error status block
// Holds register numbers, status field positions, reset values and carrier structs.
package pces_pkg;

  // ****************************************************************
  // Processor register numbers
  // ****************************************************************
  localparam logic [7:0] PCES_REG_TAG_ARRAY = 8'h7C;
  localparam logic [7:0] PCES_REG_INDEX = 8'h7D;
  localparam logic [7:0] PCES_REG_ERR_ADDR = 8'h7E;
  localparam logic [7:0] PCES_REG_STATUS = 8'h7F;

  // ****************************************************************
  // Status register field positions
  // ****************************************************************
  localparam int PCES_BIT_FORCE_HIT = 0;
  localparam int PCES_BIT_ENABLE = 1;
  localparam int PCES_BIT_FLUSH = 2;
  localparam int PCES_BIT_REFRESH = 3;
  localparam int PCES_BIT_PHIT = 4;
  localparam int PCES_BIT_INTR = 5;
  localparam int PCES_BIT_NESTED_TRAP = 6;
  localparam int PCES_BIT_FIRST_TRAP = 7;
  localparam int PCES_BIT_TAG_PAR = 8;
  localparam int PCES_BIT_MEM_PAR = 9;
  localparam int PCES_BIT_DATA_PAR = 10;
  localparam int PCES_BIT_BUS_ERR = 11;
  localparam int PCES_BIT_BHIT = 12;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] PCES_RESET_WORD = 32'h0000_0000;
  localparam logic [4:0] PCES_RESET_CAUSE = 5'h00;

  // ****************************************************************
  // Carrier structs
  // ****************************************************************
  // Processor register move request
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] number;
    logic [31:0] wdata;
  } pces_preg_req_type;

  // Error event reported by the bus interface for one reference
  typedef struct packed {
    logic valid;
    logic istream;
    logic b_hit;
    logic bus_error;
    logic data_parity;
    logic mem_parity;
    logic mem_par_requested;
    logic tag_parity;
    logic dread_hit;
    logic [31:0] address;
  } pces_err_type;

  // Memory reference presented to the cache
  typedef struct packed {
    logic valid;
    logic cpu_write;
    logic dma_write;
    logic dstream_read;
    logic [31:0] address;
    logic [31:0] wdata;
  } pces_ref_type;

endpackage : pces_pkg

// ### core/pces_top.sv
// Primary cache write policy and error status logic
// Assumes the CPU core issues register moves and reports per-reference errors,
// and that the cache array returns hit and tag lookups in the same cycle.
`timescale 1ns/1ps
module pces_top (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Processor register moves
  input wire pces_pkg::pces_preg_req_type i_preg,
  output logic [31:0] o_preg_rdata,
  output logic o_preg_ack,
  output logic o_preg_unmapped,
  // Memory references and cache lookup
  input wire pces_pkg::pces_ref_type i_ref,
  input wire logic i_lookup_hit,
  // Errors from the bus interface
  input wire pces_pkg::pces_err_type i_err,
  // Cache control
  output logic o_cache_write,
  output logic o_mem_write,
  output logic [31:0] o_mem_addr,
  output logic [31:0] o_mem_wdata,
  output logic o_invalidate,
  output logic [31:0] o_inval_addr,
  output logic o_flush,
  output logic o_cache_active,
  output logic o_force_hit,
  output logic o_refresh_enable,
  // Error signalling
  output logic o_soft_error_irq,
  output logic o_machine_check
);
  import pces_pkg::*;

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [31:0] tag_access_q;
  logic [31:0] index_q;
  logic [31:0] err_addr_q;
  logic [4:0] cause_q;
  logic [4:0] cause_d;
  logic enable_q;
  logic force_hit_q;
  logic refresh_q;
  logic phit_q;
  logic flush_q;
  logic intr_flag;
  logic first_trap_flag;
  logic nested_trap_flag;
  logic status_wr;
  logic lock_intr;
  logic lock_trap;
  logic want_intr;
  logic want_trap;
  logic set_intr;
  logic set_first_trap;
  logic set_nested_trap;
  logic latch_cause;
  logic ref_hit;
  logic [31:0] status_word;

  // ****************************************************************
  // Register access decode
  // ****************************************************************
  assign status_wr = i_preg.valid && i_preg.write && (i_preg.number == PCES_REG_STATUS);

  // Locking state of the status register
  assign lock_intr = intr_flag || first_trap_flag;
  assign lock_trap = first_trap_flag;

  // ****************************************************************
  // Error classification
  // ****************************************************************
  // Sort errors into interrupt class, machine-check class or both; tag parity is interrupt class only while lock_intr is clear, machine check on a data read hit
  always_comb begin
    want_intr = 1'b0;
    want_trap = 1'b0;
    if (i_err.valid) begin
      if (i_err.bus_error) begin
        if (i_err.istream) begin
          want_intr = 1'b1;
        end else begin
          want_trap = 1'b1;
        end
      end
      if (i_err.data_parity) begin
        if (i_err.istream) begin
          want_intr = 1'b1;
        end else begin
          want_trap = 1'b1;
        end
      end
      if (i_err.mem_parity) begin
        if (i_err.istream || !i_err.mem_par_requested) begin
          want_intr = 1'b1;
        end else begin
          want_trap = 1'b1;
        end
      end
      if (i_err.tag_parity && !lock_intr) begin
        want_intr = 1'b1;
      end
      if (i_err.tag_parity && i_err.dread_hit) begin
        want_trap = 1'b1;
      end
    end
  end

  // Flag set terms; nested machine check goes to the second trap bit
  assign set_first_trap = want_trap && !first_trap_flag;
  assign set_nested_trap = want_trap && first_trap_flag;
  assign set_intr = want_intr;
  assign latch_cause = (want_trap && !lock_trap) || (want_intr && !lock_intr);

  // Cause bits as logged for this reference
  always_comb begin
    cause_d = cause_q;
    if (latch_cause) begin
      cause_d[PCES_BIT_BHIT - 8] = i_err.b_hit;
      cause_d[PCES_BIT_BUS_ERR - 8] = i_err.bus_error;
      cause_d[PCES_BIT_DATA_PAR - 8] = i_err.data_parity;
      cause_d[PCES_BIT_MEM_PAR - 8] = i_err.mem_parity;
      cause_d[PCES_BIT_TAG_PAR - 8] = i_err.tag_parity;
    end
  end

  // Cause bits and error address latch
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      cause_q <= PCES_RESET_CAUSE;
      err_addr_q <= PCES_RESET_WORD;
    end else begin
      cause_q <= cause_d;
      if (latch_cause) begin
        err_addr_q <= i_err.address;
      end else if (i_preg.valid && i_preg.write && (i_preg.number == PCES_REG_ERR_ADDR)) begin
        err_addr_q <= i_preg.wdata;
      end
    end
  end

  // ****************************************************************
  // Sticky error flags
  // ****************************************************************
  pces_flag u_intr (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_set(set_intr),
    .i_clear(status_wr && i_preg.wdata[PCES_BIT_INTR]),
    .o_flag(intr_flag)
  );

  pces_flag u_first_trap (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_set(set_first_trap),
    .i_clear(status_wr && i_preg.wdata[PCES_BIT_FIRST_TRAP]),
    .o_flag(first_trap_flag)
  );

  pces_flag u_nested_trap (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_set(set_nested_trap),
    .i_clear(status_wr && i_preg.wdata[PCES_BIT_NESTED_TRAP]),
    .o_flag(nested_trap_flag)
  );

  // ****************************************************************
  // Control bits of the status register
  // ****************************************************************
  // Enable, force hit and refresh; flush self-clears next cycle
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      enable_q <= 1'b0;
      force_hit_q <= 1'b0;
      refresh_q <= 1'b0;
      flush_q <= 1'b0;
    end else begin
      flush_q <= status_wr && i_preg.wdata[PCES_BIT_FLUSH];
      if (status_wr) begin
        enable_q <= i_preg.wdata[PCES_BIT_ENABLE];
        force_hit_q <= i_preg.wdata[PCES_BIT_FORCE_HIT];
        refresh_q <= i_preg.wdata[PCES_BIT_REFRESH];
      end
    end
  end

  // Cache is active only while enabled and not locked by an error
  assign o_cache_active = enable_q && !first_trap_flag && !nested_trap_flag && !intr_flag;
  assign ref_hit = o_cache_active && (i_lookup_hit || force_hit_q);

  // Latched hit comparator output for data reads, writes and invalidates
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      phit_q <= 1'b0;
    end else if (i_ref.valid && (i_ref.dstream_read || i_ref.cpu_write || i_ref.dma_write)) begin
      phit_q <= ref_hit;
    end
  end

  // ****************************************************************
  // Tag and index registers
  // ****************************************************************
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      tag_access_q <= PCES_RESET_WORD;
      index_q <= PCES_RESET_WORD;
    end else if (i_preg.valid && i_preg.write) begin
      if (i_preg.number == PCES_REG_TAG_ARRAY) begin
        tag_access_q <= i_preg.wdata;
      end
      if (i_preg.number == PCES_REG_INDEX) begin
        index_q <= i_preg.wdata;
      end
    end
  end

  // ****************************************************************
  // Register read path
  // ****************************************************************
  // Status word with upper bits forced to zero
  always_comb begin
    status_word = PCES_RESET_WORD;
    status_word[PCES_BIT_BHIT:PCES_BIT_TAG_PAR] = cause_q;
    status_word[PCES_BIT_FIRST_TRAP] = first_trap_flag;
    status_word[PCES_BIT_NESTED_TRAP] = nested_trap_flag;
    status_word[PCES_BIT_INTR] = intr_flag;
    status_word[PCES_BIT_PHIT] = phit_q;
    status_word[PCES_BIT_REFRESH] = refresh_q;
    status_word[PCES_BIT_ENABLE] = enable_q;
    status_word[PCES_BIT_FORCE_HIT] = force_hit_q;
  end

  // Registered read data and acknowledge
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_preg_rdata <= PCES_RESET_WORD;
      o_preg_ack <= 1'b0;
      o_preg_unmapped <= 1'b0;
    end else begin
      o_preg_ack <= i_preg.valid;
      o_preg_unmapped <= 1'b0;
      o_preg_rdata <= PCES_RESET_WORD;
      if (i_preg.valid) begin
        case (i_preg.number)
          PCES_REG_TAG_ARRAY: o_preg_rdata <= tag_access_q;
          PCES_REG_INDEX: o_preg_rdata <= index_q;
          PCES_REG_ERR_ADDR: o_preg_rdata <= err_addr_q;
          PCES_REG_STATUS: o_preg_rdata <= status_word;
          default: o_preg_unmapped <= 1'b1;
        endcase
      end
    end
  end

  // ****************************************************************
  // Write policy
  // ****************************************************************
  // Write-through for CPU writes, invalidate on DMA write hits
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_cache_write <= 1'b0;
      o_mem_write <= 1'b0;
      o_mem_addr <= PCES_RESET_WORD;
      o_mem_wdata <= PCES_RESET_WORD;
      o_invalidate <= 1'b0;
      o_inval_addr <= PCES_RESET_WORD;
    end else begin
      o_cache_write <= i_ref.valid && i_ref.cpu_write && ref_hit;
      o_mem_write <= i_ref.valid && i_ref.cpu_write;
      o_invalidate <= i_ref.valid && i_ref.dma_write && ref_hit;
      if (i_ref.valid && i_ref.cpu_write) begin
        o_mem_addr <= i_ref.address;
        o_mem_wdata <= i_ref.wdata;
      end
      if (i_ref.valid && i_ref.dma_write) begin
        o_inval_addr <= i_ref.address;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_flush = flush_q;
  assign o_force_hit = force_hit_q;
  assign o_refresh_enable = refresh_q;
  assign o_soft_error_irq = intr_flag;
  // Machine check pulse one cycle after a trap-class error
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_machine_check <= 1'b0;
    end else begin
      o_machine_check <= want_trap;
    end
  end

endmodule : pces_top

// ### verification/pces_mem_model.sv
// Main memory model behind the write-through path
// Assumes one write pulse per cycle at most.
`timescale 1ns/1ps
module pces_mem_model (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Write port
  input wire logic i_write,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  // Capture
  output logic [31:0] o_last_addr,
  output logic [31:0] o_last_data,
  output logic [7:0] o_count
);
  // Memory copy follows every cpu write
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_count <= 8'h00;
    end else if (i_write) begin
      o_count <= o_count + 8'h01;
      o_last_addr <= i_addr;
      o_last_data <= i_wdata;
    end
  end
endmodule : pces_mem_model

// ### verification/pces_monitor.sv
// Checker for the primary cache error status block
// Bound to pces_top; sees its ports only, one clock domain.
`timescale 1ns/1ps
module pces_monitor
  import pces_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // Requests
  input wire pces_pkg::pces_preg_req_type i_preg,
  input wire pces_pkg::pces_ref_type i_ref,
  input wire logic i_lookup_hit,
  input wire pces_pkg::pces_err_type i_err,
  // Answers
  input wire logic [31:0] o_preg_rdata,
  input wire logic o_preg_ack,
  input wire logic o_preg_unmapped,
  input wire logic o_mem_write,
  input wire logic [31:0] o_mem_addr,
  input wire logic o_invalidate,
  input wire logic [31:0] o_inval_addr,
  input wire logic o_cache_active,
  input wire logic o_soft_error_irq,
  input wire logic o_machine_check
);
  // ****
  // Properties
  // ****
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  logic st_rd;
  logic in_map;
  logic clr_intr;
  // Decoded request kinds
  assign st_rd = i_preg.valid && !i_preg.write && i_preg.number == PCES_REG_STATUS;
  assign in_map = i_preg.number >= PCES_REG_TAG_ARRAY && i_preg.number <= PCES_REG_STATUS;
  assign clr_intr = i_preg.valid && i_preg.write && i_preg.number == PCES_REG_STATUS
    && i_preg.wdata[PCES_BIT_INTR];
  a_ack_one_later: assert property (i_preg.valid |=> o_preg_ack)
    else $error("ack missing after request");
  a_ack_no_spurious: assert property (!i_preg.valid |=> !o_preg_ack)
    else $error("ack without request");
  a_mapped_numbers: assert property (i_preg.valid && in_map |=> !o_preg_unmapped)
    else $error("mapped number refused");
  a_status_high_zero: assert property (st_rd |=> o_preg_rdata[31:13] == 19'h0)
    else $error("status upper bits not zero");
  a_write_through: assert property (i_ref.valid && i_ref.cpu_write |=>
    o_mem_write && o_mem_addr == $past(i_ref.address))
    else $error("cpu write not sent to memory");
  a_dma_hit_inval: assert property (i_ref.valid && i_ref.dma_write && i_lookup_hit
    && o_cache_active |=> o_invalidate && o_inval_addr == $past(i_ref.address))
    else $error("dma hit not invalidated");
  a_dma_off_quiet: assert property (i_ref.valid && i_ref.dma_write
    && !o_cache_active |=> !o_invalidate)
    else $error("invalidate with cache off");
  a_dstream_bus_mc: assert property (i_err.valid && i_err.bus_error
    && !i_err.istream |=> o_machine_check)
    else $error("no machine check on data bus error");
  a_istream_bus_irq: assert property (i_err.valid && i_err.bus_error
    && i_err.istream |=> o_soft_error_irq)
    else $error("no interrupt on instruction bus error");
  a_irq_holds: assert property (o_soft_error_irq && !clr_intr |=> o_soft_error_irq)
    else $error("interrupt dropped without clear");
  a_trap_cache_off: assert property (o_machine_check |-> !o_cache_active)
    else $error("cache active after trap");
  // Main scenarios
  c_machine_check: cover property (o_machine_check);
  c_invalidate: cover property (o_invalidate);
  c_unmapped: cover property (o_preg_unmapped);
  c_soft_irq: cover property (o_soft_error_irq);
endmodule : pces_monitor

bind pces_top pces_monitor i_mon (.i_clock, .i_reset, .i_preg, .i_ref, .i_lookup_hit, .i_err,
  .o_preg_rdata, .o_preg_ack, .o_preg_unmapped, .o_mem_write, .o_mem_addr, .o_invalidate,
  .o_inval_addr, .o_cache_active, .o_soft_error_irq, .o_machine_check);

// ### verification/tb_top.sv
// Testbench for the primary cache error status block
// Assumes the memory model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tb_top;
  import pces_pkg::*;
  logic i_clock;
  logic i_reset;
  pces_preg_req_type i_preg;
  pces_ref_type i_ref;
  pces_err_type i_err;
  logic i_lookup_hit;
  logic [31:0] o_preg_rdata, o_mem_addr, o_mem_wdata, o_inval_addr, m_addr, m_data, rd;
  logic o_preg_ack, o_preg_unmapped, o_cache_write, o_mem_write, o_invalidate, o_flush;
  logic o_cache_active, o_force_hit, o_refresh_enable, o_soft_error_irq, o_machine_check;
  logic unm;
  logic [7:0] m_count;
  int n_errors = 0;
  int check_count = 0;
  // ****
  // Error table: istream bhit bus dpar mpar req tpar dhit
  // ****
  localparam logic [7:0] EF [10] = '{8'h20, 8'hA0, 8'h10, 8'h90, 8'h0C, 8'h08, 8'h8C,
    8'h02, 8'h03, 8'h60};
  localparam logic [31:0] EX [10] = '{32'h882, 32'h822, 32'h482, 32'h422, 32'h282,
    32'h222, 32'h222, 32'h122, 32'h1A2, 32'h1882};
  localparam logic [9:0] MC = 10'h315;
  pces_top i_dut (.i_clock(i_clock), .i_reset(i_reset), .i_preg(i_preg),
    .o_preg_rdata(o_preg_rdata), .o_preg_ack(o_preg_ack),
    .o_preg_unmapped(o_preg_unmapped),
    .i_ref(i_ref), .i_lookup_hit(i_lookup_hit), .i_err(i_err),
    .o_cache_write(o_cache_write), .o_mem_write(o_mem_write), .o_mem_addr(o_mem_addr),
    .o_mem_wdata(o_mem_wdata), .o_invalidate(o_invalidate), .o_inval_addr(o_inval_addr),
    .o_flush(o_flush), .o_cache_active(o_cache_active), .o_force_hit(o_force_hit),
    .o_refresh_enable(o_refresh_enable), .o_soft_error_irq(o_soft_error_irq),
    .o_machine_check(o_machine_check));
  pces_mem_model i_mem (.i_clock(i_clock), .i_reset(i_reset), .i_write(o_mem_write),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_last_addr(m_addr),
    .o_last_data(m_data), .o_count(m_count));
  // 50 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : finish_test
  // One register move, answer taken one cycle after
  task automatic preg_move(input logic wr, input logic [7:0] num, input logic [31:0] wd);
    @(posedge i_clock);
    i_preg <= '{valid: 1'b1, write: wr, number: num, wdata: wd};
    @(posedge i_clock);
    i_preg.valid <= 1'b0;
    #1;
    chk("ack", o_preg_ack, 1'b1);
    rd = o_preg_rdata;
    unm = o_preg_unmapped;
  endtask : preg_move
  task automatic ref_step(input logic [1:0] k, input logic h, input logic [31:0] a,
    input logic [31:0] d);
    @(posedge i_clock);
    i_ref <= '{1'b1, k[1], k[0], 1'b0, a, d};
    i_lookup_hit <= h;
    @(posedge i_clock);
    i_ref.valid <= 1'b0;
    #1;
  endtask : ref_step
  task automatic err_step(input logic [7:0] f, input logic [31:0] a, input logic [31:0] exp,
    input logic mc);
    @(posedge i_clock);
    i_err <= '{1'b1, f[7], f[6], f[5], f[4], f[3], f[2], f[1], f[0], a};
    @(posedge i_clock);
    i_err.valid <= 1'b0;
    #1;
    chk("machine check", o_machine_check, mc);
    chk("irq", o_soft_error_irq, exp[5]);
    chk("cache active", o_cache_active, !(exp[7] | exp[6] | exp[5]));
    preg_move(1'b0, PCES_REG_STATUS, 32'h0);
    chk("status", rd, exp);
  endtask : err_step
  task automatic t_status;
    preg_move(1'b0, PCES_REG_STATUS, 32'h0);
    chk("status reset", rd, 32'h0);
    preg_move(1'b1, PCES_REG_STATUS, 32'hFFFF_FFFF);
    chk("flush pulse", o_flush, 1'b1);
    chk("force hit", o_force_hit, 1'b1);
    chk("refresh", o_refresh_enable, 1'b1);
    preg_move(1'b0, PCES_REG_STATUS, 32'h0);
    chk("status ones", rd, 32'h0000_000B);
    chk("flush done", o_flush, 1'b0);
    $display("status test done");
  endtask : t_status
  task automatic t_regs;
    for (int n = 0; n < 3; n++) preg_move(1'b1, 8'(8'h7C + n), 32'hA5A5_0000 | n);
    for (int n = 0; n < 3; n++) begin
      preg_move(1'b0, 8'(8'h7C + n), 32'h0);
      chk("reg", rd, 32'hA5A5_0000 | n);
    end
    preg_move(1'b1, 8'h80, 32'hFFFF_FFFF);
    preg_move(1'b0, 8'h80, 32'h0);
    chk("unmapped data", rd, 32'h0);
    chk("unmapped flag", unm, 1'b1);
    $display("register test done");
  endtask : t_regs
  task automatic t_refs;
    preg_move(1'b1, PCES_REG_STATUS, 32'h2);
    ref_step(2'b01, 1'b1, 32'h100, 32'h0);
    chk("invalidate", o_invalidate, 1'b1);
    chk("inval addr", o_inval_addr, 32'h100);
    ref_step(2'b10, 1'b1, 32'h200, 32'hCAFE_0001);
    chk("cache write", o_cache_write, 1'b1);
    chk("mem write", o_mem_write, 1'b1);
    chk("mem data", o_mem_wdata, 32'hCAFE_0001);
    // Forced hit turns a lookup miss into an invalidate
    preg_move(1'b1, PCES_REG_STATUS, 32'h3);
    ref_step(2'b01, 1'b0, 32'h700, 32'h0);
    chk("forced invalidate", o_invalidate, 1'b1);
    preg_move(1'b0, PCES_REG_STATUS, 32'h0);
    chk("hit latch", rd, 32'h13);
    preg_move(1'b1, PCES_REG_STATUS, 32'h2);
    ref_step(2'b10, 1'b0, 32'h300, 32'hCAFE_0002);
    chk("miss cache write", o_cache_write, 1'b0);
    chk("miss mem write", o_mem_write, 1'b1);
    preg_move(1'b0, PCES_REG_STATUS, 32'h0);
    chk("status miss", rd, 32'h2);
    chk("memory count", m_count, 8'h02);
    chk("memory addr", m_addr, 32'h300);
    chk("memory data", m_data, 32'hCAFE_0002);
    $display("reference test done");
  endtask : t_refs
  task automatic t_table;
    for (int i = 0; i < 10; i++) begin
      preg_move(1'b1, PCES_REG_STATUS, 32'hE2);
      err_step(EF[i], 32'h1000 + i, EX[i], MC[i]);
    end
    $display("error table test done");
  endtask : t_table
  task automatic t_nested;
    preg_move(1'b1, PCES_REG_STATUS, 32'hE2);
    err_step(8'h60, 32'h1110, 32'h1882, 1'b1);
    err_step(8'h20, 32'h2220, 32'h18C2, 1'b1);
    // Zeros in the flag bits leave them set
    preg_move(1'b1, PCES_REG_STATUS, 32'h2);
    preg_move(1'b0, PCES_REG_STATUS, 32'h0);
    chk("zero write kept", rd, 32'h18C2);
    preg_move(1'b0, PCES_REG_ERR_ADDR, 32'h0);
    chk("nested address", rd, 32'h1110);
    preg_move(1'b1, PCES_REG_STATUS, 32'hE2);
    preg_move(1'b0, PCES_REG_STATUS, 32'h0);
    chk("cleared", rd, 32'h1802);
    $display("nested test done");
  endtask : t_nested
  task automatic t_intr_lock;
    preg_move(1'b1, PCES_REG_STATUS, 32'hE2);
    err_step(8'hA0, 32'h3330, 32'h822, 1'b0);
    err_step(8'h02, 32'h4440, 32'h822, 1'b0);
    err_step(8'h0C, 32'h5550, 32'h2A2, 1'b1);
    preg_move(1'b0, PCES_REG_ERR_ADDR, 32'h0);
    chk("trap address", rd, 32'h5550);
    // Locked cache: lookups hit but nothing is cached or invalidated
    ref_step(2'b01, 1'b1, 32'h600, 32'h0);
    chk("locked invalidate", o_invalidate, 1'b0);
    ref_step(2'b10, 1'b1, 32'h640, 32'h0);
    chk("locked cache write", o_cache_write, 1'b0);
    chk("locked mem write", o_mem_write, 1'b1);
    $display("interrupt lock test done");
  endtask : t_intr_lock
  // Mid-run reset clears logged cause bits and flags
  task automatic t_reset;
    @(posedge i_clock);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_reset <= 1'b0;
    preg_move(1'b0, PCES_REG_STATUS, 32'h0);
    chk("status after reset", rd, 32'h0);
    chk("irq after reset", o_soft_error_irq, 1'b0);
    $display("reset test done");
  endtask : t_reset
  // Reset, then the scenarios in order
  initial begin
    i_reset = 1'b1;
    i_preg = '0;
    i_ref = '0;
    i_err = '0;
    i_lookup_hit = 1'b0;
    repeat (12) @(posedge i_clock);
    i_reset <= 1'b0;
    t_status();
    t_regs();
    t_refs();
    t_table();
    t_nested();
    t_intr_lock();
    t_reset();
    finish_test();
  end
  // Watchdog well beyond the run length
  initial begin
    #100_000;
    n_errors++;
    finish_test();
  end
endmodule : tb_top
